// *** verilog/lt_ctrl_pkg.sv ***
// package: register map, field layout and types for link-training control
package lt_ctrl_pkg;
   // word index 0x4D0 is a multiple of four, byte address is 4x index
   localparam logic [11:0] CTRL_INDEX = 12'h4D0;
   localparam logic [13:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
   // field positions
   localparam int TRAIN_EN_BIT = 0;
   localparam int HYST_LSB = 12;
   localparam int INIT_DIS_BIT = 15;
   localparam int LP_OVR_BIT = 16;
   localparam int LOC_OVR_BIT = 17;
   localparam int MAIN_TAP_BIT = 18;
   localparam int DFE_BYP_BIT = 19;
   localparam int FRZ_LSB = 20;
   // reset values of the fields, then freeze codes and bus encodings
   localparam logic TRAIN_EN_RST = 1'b1;
   localparam logic [2:0] HYST_RST = 3'h5;
   localparam logic INIT_DIS_RST = 1'b0;
   localparam logic LP_OVR_RST = 1'b0;
   localparam logic LOC_OVR_RST = 1'b0;
   localparam logic MAIN_TAP_RST = 1'b0;
   localparam logic DFE_BYP_SIM_RST = 1'b1;
   localparam logic DFE_BYP_HW_RST = 1'b0;
   localparam logic [1:0] FRZ_RST = 2'h1;
   localparam logic [1:0] FRZ_NONE = 2'h0;
   localparam logic [1:0] FRZ_ALL = 2'h1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // decoded controls handed to the training engine
   typedef struct packed {
      logic trainEnable;
      logic [7:0] errHysteresis;
      logic keepPmaOnFail;
      logic partnerCoefFromSw;
      logic localCoefFromSw;
      logic mainTapTrain;
      logic dfeAdaptive;
      logic dfeFreezeAll;
   } eq_ctrl_t;
endpackage

// *** verilog/hyst_decode.sv ***
// hysteresis code to error-count threshold decoder
`timescale 1ns/1ps
module hyst_decode
(
   input wire logic [2:0] code, // 3-bit hysteresis code
   output logic [7:0] count     // decoded threshold
);
   // 000 gives 0, otherwise 2 to the power of code
   always_comb
   begin
      if (code == 3'h0)
         count = 8'h00;
      else
         count = 8'h01 << code;
   end
endmodule

// *** verilog/link_training_eq_control.sv ***
// AHB-Lite control register for link-training equalisation
`timescale 1ns/1ps
module link_training_eq_control
#(
   parameter bit SIMULATION = 1'b0 // selects the DFE bypass reset value
)
(
   input wire logic clock,                  // 10 MHz clock
   input wire logic rst,                    // async reset, active high
   input wire logic hsel,                   // slave select
   input wire logic [31:0] haddr,           // byte address
   input wire logic [1:0] htrans,           // transfer type
   input wire logic hwrite,                 // write when high
   input wire logic [2:0] hsize,            // transfer size
   input wire logic [31:0] hwdata,          // write data
   input wire logic hready,                 // bus ready in
   output logic [31:0] hrdata,              // read data
   output logic hreadyout,                  // always ready
   output logic hresp,                      // always OKAY
   output lt_ctrl_pkg::eq_ctrl_t eqCtrl     // decoded controls
);
   logic [31:0] ctrlReg;
   logic wrPending;
   logic [7:0] hystCount;
   logic addrHit;
   logic [31:0] ctrlReset;

   // reset word of the control register, built from the field defaults
   localparam logic [31:0] RESET_WORD =
      (32'(lt_ctrl_pkg::TRAIN_EN_RST) << lt_ctrl_pkg::TRAIN_EN_BIT)
      | (32'(lt_ctrl_pkg::HYST_RST) << lt_ctrl_pkg::HYST_LSB)
      | (32'(lt_ctrl_pkg::INIT_DIS_RST) << lt_ctrl_pkg::INIT_DIS_BIT)
      | (32'(lt_ctrl_pkg::LP_OVR_RST) << lt_ctrl_pkg::LP_OVR_BIT)
      | (32'(lt_ctrl_pkg::LOC_OVR_RST) << lt_ctrl_pkg::LOC_OVR_BIT)
      | (32'(lt_ctrl_pkg::MAIN_TAP_RST) << lt_ctrl_pkg::MAIN_TAP_BIT)
      | (32'(SIMULATION ? lt_ctrl_pkg::DFE_BYP_SIM_RST
         : lt_ctrl_pkg::DFE_BYP_HW_RST) << lt_ctrl_pkg::DFE_BYP_BIT)
      | (32'(lt_ctrl_pkg::FRZ_RST) << lt_ctrl_pkg::FRZ_LSB);

   assign addrHit = hsel && hready && htrans == lt_ctrl_pkg::HTRANS_NONSEQ
      && haddr[13:0] == lt_ctrl_pkg::CTRL_ADDR && haddr[31:14] == 18'h0;

   // reset image of the register
   always_comb
   begin
      ctrlReset = 32'h0000_0000;
      ctrlReset[lt_ctrl_pkg::TRAIN_EN_BIT] = lt_ctrl_pkg::TRAIN_EN_RST;
      ctrlReset[lt_ctrl_pkg::HYST_LSB +: 3] = lt_ctrl_pkg::HYST_RST;
      ctrlReset[lt_ctrl_pkg::INIT_DIS_BIT] = lt_ctrl_pkg::INIT_DIS_RST;
      ctrlReset[lt_ctrl_pkg::LP_OVR_BIT] = lt_ctrl_pkg::LP_OVR_RST;
      ctrlReset[lt_ctrl_pkg::LOC_OVR_BIT] = lt_ctrl_pkg::LOC_OVR_RST;
      ctrlReset[lt_ctrl_pkg::MAIN_TAP_BIT] = lt_ctrl_pkg::MAIN_TAP_RST;
      ctrlReset[lt_ctrl_pkg::DFE_BYP_BIT] = SIMULATION ?
         lt_ctrl_pkg::DFE_BYP_SIM_RST : lt_ctrl_pkg::DFE_BYP_HW_RST;
      ctrlReset[lt_ctrl_pkg::FRZ_LSB +: 2] = lt_ctrl_pkg::FRZ_RST;
   end

   // address phase capture of a write
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wrPending <= 1'b0;
      else if (hready)
         wrPending <= addrHit && hwrite;
   end

   // control register, written in the data phase
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         ctrlReg <= RESET_WORD;
      else if (wrPending)
         ctrlReg <= hwdata;
   end

   // read data registered at the address phase
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (hready)
         hrdata <= (addrHit && !hwrite) ? ctrlReg : 32'h0000_0000;
   end

   // zero wait states, OKAY only
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   hyst_decode u_hyst
   (
      .code(ctrlReg[lt_ctrl_pkg::HYST_LSB +: 3]),
      .count(hystCount)
   );

   // decoded control outputs, registered
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         eqCtrl <= '{trainEnable: 1'b1, errHysteresis: 8'h20,
            keepPmaOnFail: 1'b0, partnerCoefFromSw: 1'b0,
            localCoefFromSw: 1'b0, mainTapTrain: 1'b0,
            dfeAdaptive: !SIMULATION, dfeFreezeAll: !SIMULATION};
      else
      begin
         // training enable
         eqCtrl.trainEnable <=
            ctrlReg[lt_ctrl_pkg::TRAIN_EN_BIT];
         eqCtrl.errHysteresis <= hystCount;
         eqCtrl.keepPmaOnFail <=
            ctrlReg[lt_ctrl_pkg::INIT_DIS_BIT];
         eqCtrl.partnerCoefFromSw <=
            ctrlReg[lt_ctrl_pkg::LP_OVR_BIT];
         eqCtrl.localCoefFromSw <=
            ctrlReg[lt_ctrl_pkg::LOC_OVR_BIT];
         eqCtrl.mainTapTrain <=
            ctrlReg[lt_ctrl_pkg::MAIN_TAP_BIT];
         eqCtrl.dfeAdaptive <=
            !ctrlReg[lt_ctrl_pkg::DFE_BYP_BIT];
         // reserved codes act as unfrozen; bypass masks the field
         eqCtrl.dfeFreezeAll <= !ctrlReg[lt_ctrl_pkg::DFE_BYP_BIT]
            && ctrlReg[lt_ctrl_pkg::FRZ_LSB +: 2]
            == lt_ctrl_pkg::FRZ_ALL;
      end
   end

   // write steps: data phase of a mapped write
   sequence s_wr_data;
      wrPending;
   endsequence

   // read steps: address phase of a mapped read
   sequence s_rd_addr;
      addrHit && !hwrite;
   endsequence

   // register image right after reset
   a_reset_image: assert property (
      @(posedge clock) $rose(!rst) |-> ctrlReg == ctrlReset)
      else $error("control reset value wrong");

   // training enable comes out of reset set
   a_reset_train: assert property (
      @(posedge clock) $rose(!rst) |-> eqCtrl.trainEnable)
      else $error("training enable reset wrong");

   // hysteresis decode follows the code
   a_hyst_map: assert property (
      @(posedge clock) disable iff (rst)
      eqCtrl.errHysteresis == (($past(ctrlReg[14:12]) == 3'h0) ? 8'h00
      : (8'h01 << $past(ctrlReg[14:12]))))
      else $error("hysteresis decode wrong");

   // init disable follows its bit
   a_pma_keep: assert property (
      @(posedge clock) disable iff (rst)
      eqCtrl.keepPmaOnFail == $past(ctrlReg[15]))
      else $error("init disable not applied");

   // a mapped write loads the whole word
   a_reg_load: assert property (
      @(posedge clock) disable iff (rst)
      s_wr_data |=> ctrlReg == $past(hwdata))
      else $error("register write lost");

   // a mapped read returns the register word
   a_read_back: assert property (
      @(posedge clock) disable iff (rst)
      s_rd_addr |=> hrdata == $past(ctrlReg))
      else $error("read data wrong");

   // partner override two cycles after the data phase
   a_lp_override: assert property (
      @(posedge clock) disable iff (rst)
      s_wr_data |-> ##2 eqCtrl.partnerCoefFromSw == $past(hwdata[16], 2))
      else $error("partner override not applied");

   // local override two cycles after the data phase
   a_loc_override: assert property (
      @(posedge clock) disable iff (rst)
      s_wr_data |-> ##2 eqCtrl.localCoefFromSw == $past(hwdata[17], 2))
      else $error("local override not applied");

   // main tap enable two cycles after the data phase
   a_main_tap: assert property (
      @(posedge clock) disable iff (rst)
      s_wr_data |-> ##2 eqCtrl.mainTapTrain == $past(hwdata[18], 2))
      else $error("main tap enable not applied");

   // adaptive dfe only without bypass
   a_dfe_bypass: assert property (
      @(posedge clock) disable iff (rst)
      eqCtrl.dfeAdaptive == !$past(ctrlReg[19]))
      else $error("dfe adaptive while bypassed");

   // freeze all exactly for code 01 without bypass
   a_freeze_mode: assert property (
      @(posedge clock) disable iff (rst)
      eqCtrl.dfeFreezeAll == (!$past(ctrlReg[19])
      && $past(ctrlReg[21:20]) == 2'h1))
      else $error("freeze mode wrong");

   // freeze needs bypass low
   a_freeze_gate: assert property (
      @(posedge clock) disable iff (rst)
      eqCtrl.dfeFreezeAll |-> $past(ctrlReg[21:19]) == 3'h2)
      else $error("freeze not gated by bypass");

   // reserved freeze codes leave the taps free
   a_reserved_free: assert property (
      @(posedge clock) disable iff (rst)
      $past(ctrlReg[21]) |-> !eqCtrl.dfeFreezeAll)
      else $error("reserved freeze code froze taps");

   // training enable two cycles after the data phase
   a_train_en: assert property (
      @(posedge clock) disable iff (rst)
      s_wr_data |-> ##2 eqCtrl.trainEnable == $past(hwdata[0], 2))
      else $error("training enable not applied");

   // bus never stalls and always answers okay
   a_bus_okay: assert property (
      @(posedge clock) disable iff (rst)
      hreadyout && !hresp)
      else $error("bus response wrong");
endmodule

// *** bench/training_engine_model.sv ***
// partner model: training engine taking the decoded controls
`timescale 1ns/1ps
module training_engine_model
(
   input wire logic clock, // system clock
   input wire lt_ctrl_pkg::eq_ctrl_t eqCtrl, // decoded controls
   output lt_ctrl_pkg::eq_ctrl_t applied // controls in use
);
   // engine picks up every control on each clock
   always_ff @(posedge clock)
      applied <= eqCtrl;
endmodule

// *** bench/link_training_eq_control_tb_top.sv ***
// testbench for the link-training control register
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module link_training_eq_control_tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic hresp;
   lt_ctrl_pkg::eq_ctrl_t eqCtrl;
   lt_ctrl_pkg::eq_ctrl_t applied;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   localparam logic [31:0] CA = 32'(lt_ctrl_pkg::CTRL_ADDR);
   localparam int BITS[5] = '{0, 15, 16, 17, 18};

   link_training_eq_control #(.SIMULATION(1'b1)) uut (.clock(clock),
      .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(lt_ctrl_pkg::HSIZE_WORD), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .eqCtrl(eqCtrl));
   training_engine_model partner (.clock(clock), .eqCtrl(eqCtrl),
      .applied(applied));

   // clock and cycle ceiling
   initial
      forever #50 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end

   // expected controls from a register word
   function automatic lt_ctrl_pkg::eq_ctrl_t exp_ctrl(logic [31:0] w);
      exp_ctrl.trainEnable = w[0];
      exp_ctrl.errHysteresis = w[14:12] == 3'h0 ? 8'h00 : 8'h01 << w[14:12];
      exp_ctrl.keepPmaOnFail = w[15];
      exp_ctrl.partnerCoefFromSw = w[16];
      exp_ctrl.localCoefFromSw = w[17];
      exp_ctrl.mainTapTrain = w[18];
      exp_ctrl.dfeAdaptive = !w[19];
      exp_ctrl.dfeFreezeAll = !w[19] && w[21:20] == 2'h1;
   endfunction

   // waits out a phase, taking read data at the ready edge
   task automatic wait_ready;
      logic rdy;
      rdy = 1'b0;
      while (rdy !== 1'b1)
      begin
         @(posedge clock);
         rdy = hreadyout;
         rd = hrdata;
      end
   endtask

   // one single-word transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= lt_ctrl_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask

   // write, then check the engine's controls and the read-back
   task automatic wr_chk(input logic [31:0] w);
      bus(1'b1, CA, w);
      repeat (3) @(posedge clock);
      `CHK(applied, exp_ctrl(w))
      bus(1'b0, CA, 32'h0);
      `CHK(rd, w)
   endtask

   task automatic test_reset;
      bus(1'b0, CA, 32'h0);
      `CHK(rd, 32'h00185001)
      `CHK(applied, exp_ctrl(32'h00185001))
      `CHK(hresp, 1'b0)
   endtask

   task automatic test_fields;
      for (int c = 0; c < 8; c++)
         wr_chk(32'h1 | (c << 12));
      foreach (BITS[i])
         wr_chk(32'h1 << BITS[i]);
      for (int v = 0; v < 8; v++)
         wr_chk(v << 19);
   endtask

   task automatic test_unmapped;
      bus(1'b1, CA + 32'h4, 32'hFFFFFFFF);
      bus(1'b0, CA + 32'h4, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b0, CA, 32'h0);
      `CHK(rd, 32'h00380000)
   endtask

   task automatic tally_and_finish;
      if (num_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      test_reset();
      test_fields();
      test_unmapped();
      tally_and_finish();
   end
endmodule
